// [uicbd_defs.svh]
// Register offsets, field positions and reset values for the serial port core
`ifndef UICBD_DEFS_SVH
`define UICBD_DEFS_SVH
`define UICBD_OFF_SOURCE   8'h04
`define UICBD_OFF_MASK     8'h04
`define UICBD_OFF_CLEAR    8'h08
`define UICBD_OFF_DIVISORS 8'h0C
`define UICBD_NUM_IRQ      13
`define UICBD_NUM_CLR      11
`define UICBD_BIT_CTS      11
`define UICBD_BIT_RTS      12
`define UICBD_MASK_RESET   13'h1FFF
`define UICBD_DIV_RESET    32'h0000_0000
`define UICBD_DIV_MIN      16'h0010
`define UICBD_RX_LSB       16
`define UICBD_TX_LSB       0
`endif

// [uicbd_pkg.sv]
// Types shared by the serial port interrupt core, peer model and testbench files
package uicbd_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } uicbd_bus_req_t;
  typedef struct packed {
    logic rts;
    logic cts;
  } uicbd_modem_t;
endpackage

// [uicbd_rate_gen.sv]
// One bit-rate tick generator dividing the reference clock by a divisor
`timescale 1ns/1ps
module uicbd_rate_gen #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] divisor_in,
  output logic                  tick_out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_tick;
  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (divisor_in == '0) begin
      // Zero divisor keeps the generator idle
      next_count = '0;
    end else if (count >= divisor_in - 1'b1) begin
      next_count = '0;
      next_tick  = 1'b1;
    end else begin
      next_count = count + 1'b1;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else begin
      count    <= next_count;
      tick_out <= next_tick;
    end
  end
  chk_idle_no_tick: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (divisor_in == '0) [*2] |-> !tick_out)
    else $error("Tick while divisor is zero");
endmodule

// [uicbd_core.sv]
// Interrupt latch, mask, clear and bit-rate divisor registers
// Summary of operation
// - Writing one at clear bit resets source
// - Modem bits mirror lines, never cleared
// - Receive rate is reference over upper divisor
// - Transmit rate is reference over lower divisor
// - Source register shows all latched flags
// - Mask bits gate output, reset set
`timescale 1ns/1ps
`include "uicbd_defs.svh"
module uicbd_core (
  input  wire logic                       clock_in,
  input  wire logic                       rst_n_in,
  input  wire uicbd_pkg::uicbd_bus_req_t  bus_in,
  output logic [31:0]                     rdata_out,
  input  wire logic [10:0]                event_in,
  input  wire uicbd_pkg::uicbd_modem_t    modem_in,
  input  wire logic                       optical_link_mode_in,
  output logic                            irq_out,
  output logic                            rx_tick_out,
  output logic                            tx_tick_out,
  output logic                            div_mismatch_out
);
  import uicbd_pkg::*;
  logic [10:0] latched;
  logic [10:0] next_latched;
  logic [12:0] mask;
  logic [12:0] next_mask;
  logic [31:0] divisors;
  logic [31:0] next_divisors;
  logic [31:0] next_rdata;
  logic [2:0]  rts_sync;
  logic [2:0]  cts_sync;
  logic        rts_level;
  logic        cts_level;
  logic [12:0] source;
  logic        wr_clear;
  // Modem lines are asynchronous, so three stages and agreement of last two
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rts_sync  <= 3'b000;
      cts_sync  <= 3'b000;
      rts_level <= 1'b0;
      cts_level <= 1'b0;
    end else begin
      rts_sync <= {rts_sync[1:0], modem_in.rts};
      cts_sync <= {cts_sync[1:0], modem_in.cts};
      if (rts_sync[2] == rts_sync[1]) rts_level <= rts_sync[2];
      if (cts_sync[2] == cts_sync[1]) cts_level <= cts_sync[2];
    end
  end
  assign wr_clear = bus_in.wr && bus_in.addr == `UICBD_OFF_CLEAR;
  // Modem bits are live levels with no latch behind them
  assign source = {rts_level, cts_level, latched};
  always_comb begin
    next_latched  = latched;
    next_mask     = mask;
    next_divisors = divisors;
    next_rdata    = 32'h0000_0000;
    if (wr_clear) begin
      next_latched = latched & ~bus_in.wdata[10:0];
    end
    // Set wins over a clear in the same cycle
    next_latched = next_latched | event_in;
    if (bus_in.wr && bus_in.addr == `UICBD_OFF_MASK) begin
      next_mask = bus_in.wdata[12:0];
    end
    if (bus_in.wr && bus_in.addr == `UICBD_OFF_DIVISORS) begin
      next_divisors = bus_in.wdata;
    end
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        `UICBD_OFF_SOURCE:   next_rdata = {19'h0_0000, source};
        `UICBD_OFF_DIVISORS: next_rdata = divisors;
        default:             next_rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      latched   <= 11'h000;
      mask      <= `UICBD_MASK_RESET;
      divisors  <= `UICBD_DIV_RESET;
      rdata_out <= 32'h0000_0000;
      irq_out   <= 1'b0;
    end else begin
      latched   <= next_latched;
      mask      <= next_mask;
      divisors  <= next_divisors;
      rdata_out <= next_rdata;
      irq_out   <= |(source & ~mask);
    end
  end
  // Software must keep both fields at least sixteen; not enforced here
  uicbd_rate_gen #(.WIDTH(16)) u_rx_gen (
    .clock_in   (clock_in),
    .rst_n_in   (rst_n_in),
    .divisor_in (divisors[31:16]),
    .tick_out   (rx_tick_out)
  );
  uicbd_rate_gen #(.WIDTH(16)) u_tx_gen (
    .clock_in   (clock_in),
    .rst_n_in   (rst_n_in),
    .divisor_in (divisors[15:0]),
    .tick_out   (tx_tick_out)
  );
  // Flag for optical mode with unequal fields, a software mistake
  assign div_mismatch_out = optical_link_mode_in &&
    divisors[31:16] != divisors[15:0];
  chk_clear_resets_flag: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    wr_clear && bus_in.wdata[0] && !event_in[0] |=> !latched[0])
    else $error("Clear write left flag set");
  chk_set_beats_clear: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    event_in[3] |=> latched[3])
    else $error("Event lost");
  // The level is taken only once the last two stages agree
  chk_modem_mirror: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    rts_sync[2] == rts_sync[1] |=> rts_level == $past(rts_sync[2]))
    else $error("Request level not taken");
  chk_cts_level: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    cts_sync[2] == cts_sync[1] |=> cts_level == $past(cts_sync[2]))
    else $error("Clear level not taken");
  chk_masked_quiet: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    (mask == 13'h1FFF) [*2] |-> !irq_out)
    else $error("Interrupt while fully masked");
  chk_unmasked_fires: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    (latched[5] && !mask[5]) |=> irq_out)
    else $error("Unmasked source did not interrupt");
  chk_source_read: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    bus_in.rd && bus_in.addr == `UICBD_OFF_SOURCE
      |=> rdata_out[10:0] == $past(latched))
    else $error("Source read wrong");
  chk_tx_period: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    $rose(tx_tick_out) && divisors[15:0] == 16'h0010 && $stable(divisors)
      |-> ##16 (tx_tick_out || divisors[15:0] != 16'h0010))
    else $error("Transmit tick period wrong");
  chk_rx_period: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    $rose(rx_tick_out) && divisors[31:16] == 16'h0010 && $stable(divisors)
      |-> ##1 !rx_tick_out [*8])
    else $error("Receive tick too early");
  // A legal divisor makes every tick a single-cycle pulse
  chk_tx_single: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    tx_tick_out && divisors[15:0] >= `UICBD_DIV_MIN |=> !tx_tick_out)
    else $error("Transmit tick too long");
  chk_rx_single: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    rx_tick_out && divisors[31:16] >= `UICBD_DIV_MIN |=> !rx_tick_out)
    else $error("Receive tick too long");
  chk_irq_follows: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    |(source & ~mask) |=> irq_out)
    else $error("Interrupt missing");
  chk_irq_quiet: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    !(|(source & ~mask)) |=> !irq_out)
    else $error("Interrupt without source");
  chk_mask_write: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    bus_in.wr && bus_in.addr == `UICBD_OFF_MASK
      |=> mask == $past(bus_in.wdata[12:0]))
    else $error("Mask write lost");
  chk_div_write: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    bus_in.wr && bus_in.addr == `UICBD_OFF_DIVISORS
      |=> divisors == $past(bus_in.wdata))
    else $error("Divisor write lost");
  chk_div_read: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    bus_in.rd && bus_in.addr == `UICBD_OFF_DIVISORS
      |=> rdata_out == $past(divisors))
    else $error("Divisor read wrong");
  chk_rdata_idle: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    !bus_in.rd |=> rdata_out == 32'h0000_0000)
    else $error("Read data without read");
  chk_unmapped_read: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    bus_in.rd && bus_in.addr != `UICBD_OFF_SOURCE &&
      bus_in.addr != `UICBD_OFF_DIVISORS |=> rdata_out == 32'h0000_0000)
    else $error("Unmapped read not zero");
  // Per-flag checks, so a fault in one bit cannot hide behind another
  for (genvar gi = 0; gi < 11; gi++) begin : g_flag
    chk_flag_set: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      event_in[gi] |=> latched[gi])
      else $error("Flag not set by event");
    chk_flag_clear: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      wr_clear && bus_in.wdata[gi] && !event_in[gi] |=> !latched[gi])
      else $error("Flag not cleared by write");
    chk_flag_hold: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      !event_in[gi] && !(wr_clear && bus_in.wdata[gi])
        |=> latched[gi] == $past(latched[gi]))
      else $error("Flag changed without cause");
  end
  cov_clear: cover property (@(posedge clock_in) wr_clear && |latched);
  cov_set_clear: cover property (@(posedge clock_in)
    wr_clear && bus_in.wdata[3] && event_in[3]);
  cov_div_write: cover property (@(posedge clock_in)
    bus_in.wr && bus_in.addr == `UICBD_OFF_DIVISORS);
  cov_irq: cover property (@(posedge clock_in) $rose(irq_out));
  cov_tick: cover property (@(posedge clock_in) rx_tick_out && tx_tick_out);
endmodule

// [uicbd_peer.sv]
// Serial peer model driving the modem handshake lines
`timescale 1ns/1ps
module uicbd_peer (
  input  wire logic              clock_in,
  input  wire logic [1:0]        level_in,
  output uicbd_pkg::uicbd_modem_t modem_out
);
  import uicbd_pkg::*;
  // Peer is unsynchronised, so the lines move off the sampling edge
  initial modem_out = '0;
  always @(posedge clock_in) begin
    modem_out <= #3 level_in;
  end
endmodule

// [uart_irq_clear_baud_divider_tb_top.sv]
// Testbench for the interrupt clear and divisor registers
`timescale 1ns/1ps
module uart_irq_clear_baud_divider_tb_top;
  import uicbd_pkg::*;
  logic           clock_in, rst_n_in, opt, rx_t, tx_t, mis, irq;
  uicbd_bus_req_t bus;
  logic [31:0]    rdata;
  logic [10:0]    ev;
  logic [1:0]     lvl;
  uicbd_modem_t   modem;
  int             n_mismatch, checked;
  uicbd_core dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .bus_in(bus),
    .rdata_out(rdata), .event_in(ev), .modem_in(modem),
    .optical_link_mode_in(opt), .irq_out(irq), .rx_tick_out(rx_t),
    .tx_tick_out(tx_t), .div_mismatch_out(mis));
  uicbd_peer peer_u (.clock_in(clock_in), .level_in(lvl), .modem_out(modem));
  initial begin
    clock_in = 0;
    forever #10 clock_in = ~clock_in;
  end
  task complete_run;
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in) bus <= '{1'b1, 1'b0, a, d};
    @(posedge clock_in) bus <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in) bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clock_in) bus <= '0;
    #1 cmp("rdata", e, rdata);
  endtask
  // Spacing between two ticks, bounded so a dead generator ends the run
  task gap(input bit rx, input int n);
    int c;
    int k;
    c = 0;
    k = 0;
    while (k < 2 && c < 200) begin
      @(posedge clock_in);
      #1 c++;
      if ((rx ? rx_t : tx_t) === 1'b1) begin
        if (k == 1) cmp("tick_gap", n, c);
        k++;
        c = 0;
      end
    end
    if (k < 2) begin
      n_mismatch++;
      complete_run;
    end
  endtask
  initial begin
    rst_n_in = 0; bus = '0; ev = '0; opt = 0; lvl = 0;
    n_mismatch = 0; checked = 0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1;
    rd(8'h0C, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    repeat (40) begin
      @(posedge clock_in);
      #1 cmp("idle_tick", 32'h0000_0000, {30'h0, rx_t, tx_t});
    end
    @(posedge clock_in) ev <= 11'h7FF;
    @(posedge clock_in) ev <= '0;
    lvl <= 2'b11;
    repeat (8) @(posedge clock_in);
    rd(8'h04, 32'h0000_1FFF);
    cmp("irq", 32'h0000_0000, {31'h0, irq});
    wr(8'h08, 32'hFFFF_FD55);
    rd(8'h04, 32'h0000_1AAA);
    wr(8'h04, 32'h0000_1FFD);
    repeat (2) @(posedge clock_in);
    #1 cmp("irq", 32'h0000_0001, {31'h0, irq});
    wr(8'h08, 32'h0000_0002);
    lvl <= 2'b00;
    repeat (8) @(posedge clock_in);
    #1 cmp("irq", 32'h0000_0000, {31'h0, irq});
    rd(8'h04, 32'h0000_02A8);
    // Legal divisors only: both fields at least sixteen
    wr(8'h0C, 32'h0014_0010);
    rd(8'h0C, 32'h0014_0010);
    gap(1, 20);
    gap(0, 16);
    opt <= 1;
    @(posedge clock_in);
    #1 cmp("div_mismatch", 32'h0000_0001, {31'h0, mis});
    wr(8'h0C, 32'h0014_0014);
    #1 cmp("div_mismatch", 32'h0000_0000, {31'h0, mis});
    gap(0, 20);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    rd(8'h0C, 32'h0014_0014);
    complete_run;
  end
endmodule
